// [verilog/isa_decoder_cfg.svh]
/*
 * Constants for the ISA I/O base-address decoder: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by its bare name from the decoder's source files.
 */
`ifndef ISA_DECODER_CFG_SVH
`define ISA_DECODER_CFG_SVH

// register byte offsets on the wishbone slave
`define CFG_CTRL_ADDR        4'h0
`define CFG_STATUS_ADDR      4'h4
`define CFG_COUNT_ADDR       4'h8

// control register
`define CFG_CTRL_ENABLE_BIT  0
`define CFG_CTRL_RESET       1'b1

// status register field positions
`define CFG_STAT_SELECT_BIT  0
`define CFG_STAT_LED_BIT     1
`define CFG_STAT_MODE_BIT    2
`define CFG_STAT_OFFSET_LSB  4
`define CFG_STAT_SWITCH_LSB  8

// switch positions: 1..6 are base bits 0..5, position 8 is the mode
`define CFG_SW_BASE_MSB      5
`define CFG_SW_MODE_BIT      7

// address segment expected in bits 15:12 for each mode
`define CFG_SEG_PLAIN        4'h0
`define CFG_SEG_OFFSET       4'ha

// access indicator pulse time and its length in clock cycles
`define CFG_CLK_MHZ          250
`define CFG_LED_PULSE_MS     20
`define CFG_LED_PULSE_CYCLES (`CFG_LED_PULSE_MS * 1000 * `CFG_CLK_MHZ)

`endif

// [verilog/isa_decoder_pkg.sv]
/*
 * Types shared by the ISA I/O base-address decoder.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package isa_decoder_pkg;
    typedef logic [19:0] isaAddr_t;
    typedef logic [7:0]  switch_t;
    typedef logic [3:0]  portOffset_t;
    typedef logic [31:0] wbData_t;
endpackage

`default_nettype wire

// [verilog/access_pulse_if.sv]
/*
 * Carrier between the decoder and its indicator pulse stretcher.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface access_pulse_if;
    logic trigger;
    logic ledOn;

    modport source  (output trigger, input ledOn);
    modport stretch (input trigger, output ledOn);
endinterface

`default_nettype wire

// [verilog/access_pulse_stretch.sv]
/*
 * Stretches a one-cycle access pulse into a visible indicator pulse.
 * Assumes a synchronous trigger; a retrigger restarts the pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "isa_decoder_cfg.svh"

module access_pulse_stretch #(
    parameter int PULSE_CYCLES = `CFG_LED_PULSE_CYCLES
) (
    input  wire logic     clk,
    input  wire logic     reset,
    access_pulse_if.stretch pulse
);
    localparam int CW = $clog2(PULSE_CYCLES + 1);

    logic [CW-1:0] remain_r;
    logic          ledOn_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            remain_r <= '0;
        end else if (pulse.trigger) begin
            remain_r <= CW'(PULSE_CYCLES - 1);
        end else if (remain_r != '0) begin
            remain_r <= remain_r - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ledOn_r <= 1'b0;
        end else begin
            ledOn_r <= pulse.trigger || (remain_r != '0);
        end
    end

    assign pulse.ledOn = ledOn_r;

    a_led_follows_trigger: assert property (
        @(posedge clk) disable iff (reset)
        pulse.trigger |=> pulse.ledOn)
        else $error("indicator did not light after an access");
endmodule

`default_nettype wire

// [verilog/isa_io_address_decoder.sv]
/*
 * Base-address decoder for an 8-bit ISA I/O module with a wishbone
 * register slave for control and status.
 * Assumes ISA pins already synchronous to clk and a classic wishbone
 * master that holds each request until it sees ack.
 */
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "isa_decoder_cfg.svh"

// Behaviour
// - match switch base bits 5:0 against host address bits 9:4
// - decode address bits 19:4; bits 19:16 must be zero
// - mode switch 1: address bits 15:12 must be 0h
// - mode switch 0: address bits 15:12 must be Ah
// - a match claims sixteen byte ports chosen by address bits 3:0
// - switch positions 1..6 give base bits 0..5; position 8 the mode
// - every decoded access lights the indicator for a short pulse
// - the port offset is passed on uninterpreted to the user logic
module isa_io_address_decoder
    import isa_decoder_pkg::*;
#(
    parameter int LED_PULSE_CYCLES = `CFG_LED_PULSE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire isaAddr_t    isaAddr,
    input  wire logic        addrEnable,
    input  wire logic        ioReadN,
    input  wire logic        ioWriteN,
    input  wire switch_t     addressSelectSwitch,
    output logic             moduleSelect,
    output portOffset_t      portOffset,
    output logic             portRead,
    output logic             portWrite,
    output logic             accessIndicatorLed,
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [3:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire wbData_t     wbDatW,
    output wbData_t          wbDatR,
    output logic             wbAck
);

    function automatic logic addrMatch(input isaAddr_t a, input switch_t sw);
        logic [3:0] seg;
        seg = sw[`CFG_SW_MODE_BIT] ? `CFG_SEG_PLAIN : `CFG_SEG_OFFSET;
        return (a[9:4] == sw[`CFG_SW_BASE_MSB:0])
            && (a[11:10] == 2'b00)
            && (a[15:12] == seg)
            && (a[19:16] == 4'h0);
    endfunction

    access_pulse_if pulse ();

    logic        decodeEnable_r;
    logic        moduleSelect_r;
    portOffset_t portOffset_r;
    logic        portRead_r;
    logic        portWrite_r;
    logic [15:0] accessCount_r;
    logic        ack_r;
    wbData_t     datR_r;
    logic        ioCycle;
    logic        selectNow;
    logic        accessStart;
    logic        wbReq;
    logic        wbWrite;

    assign ioCycle     = !addrEnable && (!ioReadN || !ioWriteN);
    assign selectNow   = decodeEnable_r && ioCycle
                         && addrMatch(isaAddr, addressSelectSwitch);
    assign accessStart = selectNow && !moduleSelect_r;
    assign pulse.trigger = accessStart;

    access_pulse_stretch #(
        .PULSE_CYCLES (LED_PULSE_CYCLES)
    ) u_stretch (
        .clk   (clk),
        .reset (reset),
        .pulse (pulse)
    );

    // decode outputs, registered one cycle behind the pins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            moduleSelect_r <= 1'b0;
            portRead_r     <= 1'b0;
            portWrite_r    <= 1'b0;
        end else begin
            moduleSelect_r <= selectNow;
            portRead_r     <= selectNow && !ioReadN;
            portWrite_r    <= selectNow && !ioWriteN;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            portOffset_r <= '0;
        end else if (selectNow) begin
            portOffset_r <= isaAddr[3:0];
        end
    end

    assign moduleSelect       = moduleSelect_r;
    assign portOffset         = portOffset_r;
    assign portRead           = portRead_r;
    assign portWrite          = portWrite_r;
    assign accessIndicatorLed = pulse.ledOn;

    // wishbone slave: ack one cycle after the request, dropped after
    assign wbReq   = wbCyc && wbStb;
    assign wbWrite = wbReq && wbWe && ack_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wbReq && !ack_r;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            datR_r <= '0;
        end else if (wbReq && !ack_r) begin
            datR_r <= '0;
            unique case (wbAdr)
                `CFG_CTRL_ADDR: begin
                    datR_r[`CFG_CTRL_ENABLE_BIT] <= decodeEnable_r;
                end
                `CFG_STATUS_ADDR: begin
                    datR_r[`CFG_STAT_SELECT_BIT] <= moduleSelect_r;
                    datR_r[`CFG_STAT_LED_BIT]    <= pulse.ledOn;
                    datR_r[`CFG_STAT_MODE_BIT]   <=
                        addressSelectSwitch[`CFG_SW_MODE_BIT];
                    datR_r[`CFG_STAT_OFFSET_LSB +: 4] <= portOffset_r;
                    datR_r[`CFG_STAT_SWITCH_LSB +: 8] <= addressSelectSwitch;
                end
                `CFG_COUNT_ADDR: begin
                    datR_r[15:0] <= accessCount_r;
                end
                default: begin
                    datR_r <= '0;
                end
            endcase
        end
    end

    assign wbDatR = datR_r;
    assign wbAck  = ack_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            decodeEnable_r <= `CFG_CTRL_RESET;
        end else if (wbWrite && wbAdr == `CFG_CTRL_ADDR && wbSel[0]) begin
            decodeEnable_r <= wbDatW[`CFG_CTRL_ENABLE_BIT];
        end
    end

    // a new access in the clearing cycle still counts
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            accessCount_r <= '0;
        end else if (wbWrite && wbAdr == `CFG_COUNT_ADDR) begin
            accessCount_r <= accessStart ? 16'h0001 : 16'h0000;
        end else if (accessStart) begin
            accessCount_r <= accessCount_r + 16'h0001;
        end
    end

    // helper copies of the pins and of the enable register for the checks below
    isaAddr_t addrSeen_r;
    switch_t  swSeen_r;
    logic     enSeen_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            addrSeen_r <= '0;
            swSeen_r   <= '0;
            enSeen_r   <= 1'b0;
        end else begin
            addrSeen_r <= isaAddr;
            swSeen_r   <= addressSelectSwitch;
            enSeen_r   <= decodeEnable_r;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_ioAccess;
        !addrEnable && (!ioReadN || !ioWriteN);
    endsequence

    sequence s_selected;
        moduleSelect && portOffset == isaAddr[3:0];
    endsequence

    a_select_on_match: assert property (
        (decodeEnable_r && addrMatch(isaAddr, addressSelectSwitch))
        and s_ioAccess |=> moduleSelect)
        else $error("matching access was not selected");

    a_base_bits_match: assert property (
        moduleSelect |-> addrSeen_r[9:4] == swSeen_r[5:0] && enSeen_r)
        else $error("selected with base bits unequal to switch");

    a_upper_bits_zero: assert property (
        moduleSelect |-> addrSeen_r[19:16] == 4'h0)
        else $error("selected with address bits 19:16 set");

    a_plain_segment: assert property (
        moduleSelect && swSeen_r[7] |-> addrSeen_r[15:12] == 4'h0)
        else $error("plain mode selected outside segment 0");

    a_offset_segment: assert property (
        moduleSelect && !swSeen_r[7] |-> addrSeen_r[15:12] == 4'ha)
        else $error("offset mode selected outside segment A");

    a_offset_passed: assert property (
        moduleSelect |-> portOffset == addrSeen_r[3:0])
        else $error("port offset differs from address bits 3:0");

    a_window_held: assert property (
        (selectNow ##1 (selectNow && $stable(isaAddr))) |-> s_selected)
        else $error("held access lost its sixteen byte window");

    a_aen_ignored: assert property (
        addrEnable |=> !moduleSelect && !portRead && !portWrite)
        else $error("cycle with address enable high was decoded");

    a_mid_bits_zero: assert property (
        moduleSelect |-> addrSeen_r[11:10] == 2'b00)
        else $error("selected with address bits 11:10 set");

    a_led_pulse: assert property (
        accessStart |=> accessIndicatorLed [*2])
        else $error("indicator pulse too short after access");

    a_ack_single: assert property (
        wbAck |=> !wbAck)
        else $error("ack held for more than one cycle");

    a_ack_answers: assert property (
        wbCyc && wbStb && !wbAck |=> wbAck)
        else $error("wishbone request left without ack");
endmodule

`default_nettype wire

// [tb/isa_host_model.sv]
/*
 * Host processor model that drives ISA I/O cycles into the decoder.
 * Assumes its tasks are called just after a rising edge of clk.
 */
`timescale 1ns/1ps
`default_nettype none

module isa_host_model
    import isa_decoder_pkg::*;
(
    input  wire logic clk,
    output isaAddr_t  isaAddr,
    output logic      addrEnable,
    output logic      ioReadN,
    output logic      ioWriteN
);
    initial begin
        isaAddr = 20'h00000;
        addrEnable = 1'b1;
        ioReadN = 1'b1;
        ioWriteN = 1'b1;
    end

    // one strobe at a time, address enable as commanded
    task automatic start(input isaAddr_t a, input logic aen, input logic rd);
        isaAddr <= a;
        addrEnable <= aen;
        ioReadN <= !rd;
        ioWriteN <= rd;
    endtask

    // released address lines show no stale value
    task automatic stop();
        ioReadN <= 1'b1;
        ioWriteN <= 1'b1;
        addrEnable <= 1'b1;
        isaAddr <= ~isaAddr;
    endtask
endmodule

`default_nettype wire

// [tb/isa_io_address_decoder_tb.sv]
/*
 * Self-checking bench for the ISA I/O base-address decoder.
 * Assumes a short indicator pulse parameter and a one-cycle wishbone ack.
 */
`timescale 1ns/1ps
`default_nettype none
`include "isa_decoder_cfg.svh"

module isa_io_address_decoder_tb
    import isa_decoder_pkg::*;
;
    localparam int PULSE = 16;
    logic clk = 1'b0, reset = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [3:0] wbAdr = 4'h0, wbSel = 4'h0;
    wbData_t wbDatW = 32'h0, wbDatR, rd;
    switch_t sw = 8'h91;
    isaAddr_t isaAddr;
    logic addrEnable, ioReadN, ioWriteN, moduleSelect, portRead, portWrite;
    logic accessIndicatorLed, wbAck;
    portOffset_t portOffset;
    int errTotal = 0, nTests = 0;

    always #2 clk = ~clk;

    isa_host_model host_u (.clk(clk), .isaAddr(isaAddr),
        .addrEnable(addrEnable), .ioReadN(ioReadN), .ioWriteN(ioWriteN));
    isa_io_address_decoder #(.LED_PULSE_CYCLES(PULSE)) dut_u (.clk(clk),
        .reset(reset), .isaAddr(isaAddr), .addrEnable(addrEnable),
        .ioReadN(ioReadN), .ioWriteN(ioWriteN), .addressSelectSwitch(sw),
        .moduleSelect(moduleSelect), .portOffset(portOffset),
        .portRead(portRead), .portWrite(portWrite),
        .accessIndicatorLed(accessIndicatorLed), .wbCyc(wbCyc),
        .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
        .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck));

    task automatic report_and_stop();
        if (errTotal == 0 && nTests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        nTests++;
        if (!ok) begin
            errTotal++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // classic wishbone cycle; hold until ack is sampled high
    task automatic wb(input logic we, input logic [3:0] a, input wbData_t d);
        int n;
        @(posedge clk);
        wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we;
        wbAdr <= a; wbSel <= 4'hf; wbDatW <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 20) begin
                check(1'b0, "wishbone ack missing");
                report_and_stop();
            end
        end while (wbAck !== 1'b1);
        rd = wbDatR;
        wbCyc <= 1'b0; wbStb <= 1'b0;
    endtask

    // one host I/O cycle, then compare the decoded outputs
    task automatic io(input switch_t s, input isaAddr_t a, input logic aen,
                      input logic r, input logic exp);
        @(posedge clk);
        sw <= s;
        host_u.start(a, aen, r);
        @(posedge clk);
        #1;
        check(moduleSelect === exp, "select");
        if (exp) begin
            check(portOffset === a[3:0] && portRead === r
                  && portWrite === !r, "port offset or strobe");
        end
        @(posedge clk);
        host_u.stop();
        repeat (2) @(posedge clk);
        if (exp) check(accessIndicatorLed === 1'b1, "led off");
    endtask

    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        wb(1'b0, `CFG_CTRL_ADDR, 32'h0);
        check(rd[0] === `CFG_CTRL_RESET, "ctrl reset value");
        wb(1'b0, 4'hc, 32'h0);
        check(rd === 32'h0, "unmapped read");
        io(8'h91, 20'h00115, 1'b0, 1'b1, 1'b1);
        io(8'h11, 20'h0a11f, 1'b0, 1'b0, 1'b1);
        io(8'h91, 20'h0a115, 1'b0, 1'b1, 1'b0);
        io(8'h11, 20'h00115, 1'b0, 1'b1, 1'b0);
        io(8'h91, 20'h10115, 1'b0, 1'b1, 1'b0);
        io(8'h91, 20'h00915, 1'b0, 1'b1, 1'b0);
        io(8'h91, 20'h00115, 1'b1, 1'b1, 1'b0);
        io(8'h91, 20'h00125, 1'b0, 1'b1, 1'b0);
        io(8'hbf, 20'h003f0, 1'b0, 1'b1, 1'b1);
        io(8'h00, 20'h0a000, 1'b0, 1'b0, 1'b1);
        repeat (PULSE + 8) @(posedge clk);
        check(accessIndicatorLed === 1'b0, "led stuck on");
        wb(1'b0, `CFG_COUNT_ADDR, 32'h0);
        check(rd[15:0] === 16'h0004, "access count");
        wb(1'b1, `CFG_COUNT_ADDR, 32'h0);
        wb(1'b0, `CFG_COUNT_ADDR, 32'h0);
        check(rd[15:0] === 16'h0000, "count clear");
        wb(1'b0, `CFG_STATUS_ADDR, 32'h0);
        check(rd === 32'h0000_0000, "status switch");
        wb(1'b1, `CFG_CTRL_ADDR, 32'h0);
        io(8'h91, 20'h00115, 1'b0, 1'b1, 1'b0);
        wb(1'b1, `CFG_CTRL_ADDR, 32'h1);
        io(8'h91, 20'h00115, 1'b0, 1'b1, 1'b1);
        wb(1'b0, `CFG_STATUS_ADDR, 32'h0);
        check(rd === 32'h0000_9156, "status fields");
        report_and_stop();
    end
endmodule

`default_nettype wire
